// File: common/dsef_params.svh
`ifndef DSEF_PARAMS_SVH
`define DSEF_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define DSEF_OFS_CTRL 8'h00
`define DSEF_OFS_MAX_CURRENT 8'h04
`define DSEF_OFS_STOP_CURRENT 8'h08
`define DSEF_OFS_ERR_MASK 8'h0C
`define DSEF_OFS_WARN_MASK 8'h10
`define DSEF_OFS_JITTER_TIME 8'h14
`define DSEF_OFS_ACK_TIME 8'h18
`define DSEF_OFS_STATUS 8'h1C
`define DSEF_OFS_IRQ_STATUS 8'h20
`define DSEF_OFS_IRQ_CLEAR 8'h24
`define DSEF_OFS_IRQ_ENABLE 8'h28

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define DSEF_CTRL_RANGE_BIT 0
`define DSEF_CTRL_ESTOP_LSB 1
`define DSEF_CTRL_PITCH_LSB 3
`define DSEF_CTRL_DIR_NEG_BIT 5

// ----------------------------------------------------------------------
// event bits (irq status, clear and enable share this layout)
// ----------------------------------------------------------------------
`define DSEF_EV_MOTOR_TYPE 0
`define DSEF_EV_CURVE 1
`define DSEF_EV_SENSOR_ABSENT 2
`define DSEF_EV_SENSOR_WARN 3
`define DSEF_EV_ESTOP 4
`define DSEF_EV_STATE 5
`define DSEF_EV_W 6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DSEF_RST_CTRL 6'h00
`define DSEF_RST_MAX_CURRENT 16'h0BB8
`define DSEF_RST_STOP_CURRENT 16'h0000
`define DSEF_RST_ERR_MASK 3'h7
`define DSEF_RST_WARN_MASK 1'h1
`define DSEF_RST_JITTER_TIME 16'h000A
`define DSEF_RST_ACK_TIME 16'h000A
`define DSEF_RST_IRQ_ENABLE 6'h00

// ----------------------------------------------------------------------
// currents in mA, pole pitch in um
// ----------------------------------------------------------------------
`define DSEF_CEIL_HI_MA 16'h0BB8
`define DSEF_CEIL_LO_MA 16'h07D0
`define DSEF_PITCH_1MM_UM 16'h03E8
`define DSEF_PITCH_2MM_UM 16'h07D0
`define DSEF_PITCH_5MM_UM 16'h1388

// ----------------------------------------------------------------------
// timing: times are programmed in microseconds
// ----------------------------------------------------------------------
`define DSEF_CLK_PERIOD_NS 50
`define DSEF_TICK_NS 1000
`define DSEF_TICK_CYCLES (`DSEF_TICK_NS / `DSEF_CLK_PERIOD_NS)

`endif

// File: common/dsef_pkg.sv
package dsef_pkg;
  typedef enum logic [1:0] {DSEF_ESTOP_OFF, DSEF_ESTOP_FREEZE, DSEF_ESTOP_SET} dsef_estop_e;
  typedef enum logic [1:0] {DSEF_PITCH_1MM, DSEF_PITCH_2MM, DSEF_PITCH_5MM} dsef_pitch_e;
  typedef enum logic {DSEF_RUN, DSEF_STOPPED} dsef_run_e;
  typedef logic [15:0] dsef_ma_t;
endpackage

// File: verif/dsef_ctrl_model.sv
`timescale 1ns/1ps
module dsef_ctrl_model (
  input wire logic mclk,
  output logic [3:0] sel_in
);
  initial begin
    sel_in = 4'h0;
  end

  // ------------------------------------------------------------
  // state selection from the higher-level controller
  // ------------------------------------------------------------
  // bits move one at a time, skew plus one cycles apart, so every change of more
  // than one bit passes through the intermediate codes a real controller shows
  task automatic send(input logic [3:0] code, input int skew);
    for (int b = 0; b < 4; b++) begin
      if (sel_in[b] !== code[b]) begin
        @(posedge mclk);
        sel_in[b] <= code[b];
        repeat (skew) @(posedge mclk);
      end
    end
  endtask
endmodule // dsef_ctrl_model

// File: verif/testbench.sv
`timescale 1ns/1ps
`include "dsef_params.svh"
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, state_strobe, in_position, error_state, warning, travel_outward, irq;
  logic [3:0] sel_in, drive_state;
  logic [15:0] current_cmd_ma, pitch_um;
  logic estop_in = 1'b0;
  logic [2:0] flt = 3'h0;
  logic sensor_misconnect = 1'b0;
  logic at_target = 1'b1;
  logic [15:0] setpoint_ma = 16'h0000;
  logic sin_leads_cos = 1'b0;
  logic [31:0] q;
  logic e;
  int error_cnt = 0;
  int checked = 0;
  int strobes = 0;

  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    if (state_strobe === 1'b1) begin
      strobes <= strobes + 1;
    end
  end

  dsef_ctrl_model u_ctl (.mclk, .sel_in);
  dsef_drive_supervisor DUT (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sel_in, .estop_in, .motor_type_fault(flt[0]), .curve_fault(flt[1]),
    .sensor_absent(flt[2]), .sensor_misconnect, .at_target, .setpoint_ma, .sin_leads_cos,
    .current_cmd_ma, .drive_state, .state_strobe, .in_position, .error_state, .warning,
    .pitch_um, .travel_outward, .irq
  );

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, q);
  endtask

  task automatic adopt(input logic [3:0] c);
    u_ctl.send(c, 0);
    for (int i = 0; i < 200 && drive_state !== c; i++) @(posedge mclk);
    chk("drive_state", {28'h000_0000, c}, {28'h000_0000, drive_state});
  endtask

  task automatic wstrobe();
    for (int i = 0; i < 200 && state_strobe !== 1'b1; i++) @(posedge mclk);
    chk("state_strobe", 1'b1, state_strobe);
  endtask

  task automatic pulse(input int k);
    @(posedge mclk);
    flt[k] <= 1'b1;
    @(posedge mclk);
    flt[k] <= 1'b0;
    cyc(3);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdc("ctrl", `DSEF_OFS_CTRL, `DSEF_RST_CTRL);
    rdc("max_current", `DSEF_OFS_MAX_CURRENT, `DSEF_RST_MAX_CURRENT);
    rdc("stop_current", `DSEF_OFS_STOP_CURRENT, `DSEF_RST_STOP_CURRENT);
    rdc("err_mask", `DSEF_OFS_ERR_MASK, `DSEF_RST_ERR_MASK);
    rdc("warn_mask", `DSEF_OFS_WARN_MASK, `DSEF_RST_WARN_MASK);
    rdc("jitter_time", `DSEF_OFS_JITTER_TIME, `DSEF_RST_JITTER_TIME);
    rdc("ack_time", `DSEF_OFS_ACK_TIME, `DSEF_RST_ACK_TIME);
    rdc("irq_enable", `DSEF_OFS_IRQ_ENABLE, `DSEF_RST_IRQ_ENABLE);
    chk("reset pitch_um", {16'h0000, `DSEF_PITCH_1MM_UM}, pitch_um);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk("unmapped pslverr", 1'b1, e);
    chk("unmapped data", 32'h0000_0000, q);
    apb(1'b1, `DSEF_OFS_STATUS, 32'hFFFF_FFFF);
    chk("read-only pslverr", 1'b1, e);
  endtask

  task automatic t_select();
    int s0;
    s0 = strobes;
    u_ctl.send(4'h5, 0);
    cyc(10);
    u_ctl.send(4'h0, 0);
    for (int k = 0; k < 2; k++) begin
      u_ctl.send(4'h1, 30);
      u_ctl.send(4'h0, 30);
    end
    cyc(60);
    chk("state after short codes", 32'h0000_0000, drive_state);
    chk("strobes after short codes", s0, strobes);
    u_ctl.send(4'h3, 2);
    cyc(30);
    chk("state before interval", 32'h0000_0000, drive_state);
    adopt(4'h3);
    cyc(1);
    chk("one strobe for 0 to 3", s0 + 1, strobes);
    for (int k = 0; k < 16; k++) begin
      if (k != 3) begin
        adopt(4'(k));
      end
    end
  endtask

  task automatic t_inpos();
    int n;
    u_ctl.send(4'h6, 0);
    wstrobe();
    cyc(1);
    chk("in_position after command", 1'b0, in_position);
    n = 0;
    while (in_position !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk("ack interval held", 1'b1, n >= 40);
    chk("in_position after ack", 1'b1, in_position);
    at_target <= 1'b0;
    u_ctl.send(4'h7, 0);
    wstrobe();
    cyc(80);
    chk("in_position off target", 1'b0, in_position);
    at_target <= 1'b1;
    cyc(3);
    chk("in_position on target", 1'b1, in_position);
  endtask

  task automatic t_ceiling();
    logic [63:0] row [4] = '{
      {16'h0000, 16'h0BB8, 16'h09C4, 16'h07D0}, {16'h0001, 16'h0BB8, 16'h09C4, 16'h09C4},
      {16'h0001, 16'h0BB8, 16'h0DAC, 16'h0BB8}, {16'h0001, 16'h0708, 16'h09C4, 16'h0708}};
    for (int i = 0; i < 4; i++) begin
      wr(`DSEF_OFS_CTRL, {16'h0000, row[i][63:48]});
      wr(`DSEF_OFS_MAX_CURRENT, {16'h0000, row[i][47:32]});
      setpoint_ma <= row[i][31:16];
      cyc(4);
      chk("run current", {16'h0000, row[i][15:0]}, current_cmd_ma);
    end
  endtask

  task automatic t_estop();
    logic [15:0] stop_exp [3] = '{16'h0000, 16'h05DC, 16'h09C4};
    wr(`DSEF_OFS_MAX_CURRENT, 32'h0000_0BB8);
    wr(`DSEF_OFS_STOP_CURRENT, 32'h0000_09C4);
    for (int m = 0; m < 3; m++) begin
      wr(`DSEF_OFS_CTRL, 32'((m << 1) | 1));
      setpoint_ma <= 16'h05DC;
      cyc(4);
      estop_in <= 1'b1;
      cyc(6);
      // a later setpoint change must not leak through the stop command in any of the three modes
      setpoint_ma <= 16'h01F4;
      cyc(4);
      chk("stop current", {16'h0000, stop_exp[m]}, current_cmd_ma);
      if (m == 0) begin
        rdc("status stopped", `DSEF_OFS_STATUS, 32'h0000_01B9);
      end
      estop_in <= 1'b0;
      cyc(6);
      chk("released current", 32'h0000_01F4, current_cmd_ma);
    end
    apb(1'b0, `DSEF_OFS_IRQ_STATUS, 32'h0000_0000);
    chk("estop event", 1'b1, q[`DSEF_EV_ESTOP]);
  endtask

  task automatic t_faults();
    wr(`DSEF_OFS_IRQ_CLEAR, 32'h0000_003F);
    for (int k = 0; k < 3; k++) begin
      pulse(k);
      chk("error_state on fault", 1'b1, error_state);
      rdc("fault event", `DSEF_OFS_IRQ_STATUS, 32'h0000_0001 << k);
      wr(`DSEF_OFS_IRQ_CLEAR, 32'h0000_0001 << k);
      cyc(3);
      chk("error_state cleared", 1'b0, error_state);
    end
    wr(`DSEF_OFS_ERR_MASK, 32'h0000_0006);
    pulse(0);
    chk("masked fault", 1'b0, error_state);
    rdc("masked fault event", `DSEF_OFS_IRQ_STATUS, 32'h0000_0001);
    wr(`DSEF_OFS_ERR_MASK, 32'h0000_0007);
    wr(`DSEF_OFS_IRQ_CLEAR, 32'h0000_0001);
    sensor_misconnect <= 1'b1;
    cyc(3);
    chk("warning", 1'b1, warning);
    chk("no error from warning", 1'b0, error_state);
    chk("irq while disabled", 1'b0, irq);
    wr(`DSEF_OFS_IRQ_ENABLE, 32'h0000_0008);
    cyc(2);
    chk("irq raised", 1'b1, irq);
    wr(`DSEF_OFS_WARN_MASK, 32'h0000_0000);
    cyc(3);
    chk("warning masked", 1'b0, warning);
    sensor_misconnect <= 1'b0;
    wr(`DSEF_OFS_IRQ_CLEAR, 32'h0000_0008);
    cyc(2);
    chk("irq cleared", 1'b0, irq);
  endtask

  task automatic t_sensor();
    logic [15:0] pit [4] = '{`DSEF_PITCH_1MM_UM, `DSEF_PITCH_2MM_UM, `DSEF_PITCH_5MM_UM,
      `DSEF_PITCH_1MM_UM};
    for (int p = 0; p < 4; p++) begin
      wr(`DSEF_OFS_CTRL, 32'(p << 3));
      cyc(2);
      chk("pitch_um", {16'h0000, pit[p]}, pitch_um);
    end
    for (int v = 0; v < 4; v++) begin
      wr(`DSEF_OFS_CTRL, 32'((v >> 1) << 5));
      sin_leads_cos <= v[0];
      cyc(3);
      chk("travel_outward", v[0] ^ v[1], travel_outward);
    end
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    t_reset();
    // short filter and acknowledge times keep the run brief: two microseconds each
    wr(`DSEF_OFS_JITTER_TIME, 32'h0000_0002);
    wr(`DSEF_OFS_ACK_TIME, 32'h0000_0002);
    t_select();
    t_inpos();
    t_ceiling();
    t_estop();
    t_faults();
    t_sensor();
    end_sim();
  end

  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    end_sim();
  end
endmodule // testbench

// File: verilog/dsef_drive_supervisor.sv
// How it works
// R1: controller picks one of 16 states with a 4-bit code on the select pins.
// R2: new code adopted only after all select pins stay stable for jitter time.
// R3: stability timer restarts whenever any select pin changes before expiry.
// R4: after a command executes, in-position stays low at least the ack time.
// R5: in-position rises only after ack time and motor reached target.
// R6: emergency stop in off mode drives current command to zero.
// R7: freeze mode latches current at stop instant and keeps driving it.
// R8: set-current mode switches to programmed stop current at once.
// R9: motor type fault enters error state when enabled in error mask.
// R10: profile lookup fault flagged, error state when enabled in mask.
// R11: sensor absent fault flagged, error state when enabled in mask.
// R12: sensor mounting fault reported as warning when enabled in warn mask.
// R13: current ceiling is 3 A with range switch set, else 2 A.
// R14: ceiling further clamped to programmed maximal current when lower.
// R15: sensor pitch selectable 1, 2 or 5 mm, scaling position decoding.
// R16: direction bit selects which quadrature lead means outward travel.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "dsef_params.svh"
module dsef_drive_supervisor
  import dsef_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] sel_in,
  input wire logic estop_in,
  input wire logic motor_type_fault,
  input wire logic curve_fault,
  input wire logic sensor_absent,
  input wire logic sensor_misconnect,
  input wire logic at_target,
  input wire logic [15:0] setpoint_ma,
  input wire logic sin_leads_cos,
  output logic [15:0] current_cmd_ma,
  output logic [3:0] drive_state,
  output logic state_strobe,
  output logic in_position,
  output logic error_state,
  output logic warning,
  output logic [15:0] pitch_um,
  output logic travel_outward,
  output logic irq
);
  // --------------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------------
  logic [5:0] ctrl;
  dsef_ma_t max_current;
  dsef_ma_t stop_current;
  logic [2:0] err_mask;
  logic [0:0] warn_mask;
  logic [15:0] jitter_time;
  logic [15:0] ack_time;
  logic [`DSEF_EV_W-1:0] irq_status;
  logic [`DSEF_EV_W-1:0] irq_enable;
  logic [`DSEF_EV_W-1:0] events;
  dsef_run_e run_state;

  wire sel_ctrl = paddr == `DSEF_OFS_CTRL;
  wire sel_max = paddr == `DSEF_OFS_MAX_CURRENT;
  wire sel_stop = paddr == `DSEF_OFS_STOP_CURRENT;
  wire sel_emask = paddr == `DSEF_OFS_ERR_MASK;
  wire sel_wmask = paddr == `DSEF_OFS_WARN_MASK;
  wire sel_jit = paddr == `DSEF_OFS_JITTER_TIME;
  wire sel_ack = paddr == `DSEF_OFS_ACK_TIME;
  wire sel_stat = paddr == `DSEF_OFS_STATUS;
  wire sel_ists = paddr == `DSEF_OFS_IRQ_STATUS;
  wire sel_iclr = paddr == `DSEF_OFS_IRQ_CLEAR;
  wire sel_ien = paddr == `DSEF_OFS_IRQ_ENABLE;
  wire mapped = sel_ctrl | sel_max | sel_stop | sel_emask | sel_wmask | sel_jit | sel_ack |
                sel_stat | sel_ists | sel_iclr | sel_ien;
  wire wr_en = psel & penable & pwrite & mapped;
  wire rd_setup = psel & ~penable;
  // writes to the read-only registers are errors; reads of the clear register return zero
  wire ro_write = pwrite & (sel_stat | sel_ists);

  wire [31:0] status_word = {23'h00_0000, run_state == DSEF_STOPPED, in_position, drive_state,
                             warning, error_state, current_cmd_ma == 16'h0000};
  wire [31:0] rd_mux =
    sel_ctrl ? {26'h000_0000, ctrl} :
    sel_max ? {16'h0000, max_current} :
    sel_stop ? {16'h0000, stop_current} :
    sel_emask ? {29'h0000_0000, err_mask} :
    sel_wmask ? {31'h0000_0000, warn_mask} :
    sel_jit ? {16'h0000, jitter_time} :
    sel_ack ? {16'h0000, ack_time} :
    sel_stat ? status_word :
    sel_ists ? {26'h000_0000, irq_status} :
    sel_ien ? {26'h000_0000, irq_enable} : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = psel & penable & (~mapped | ro_write);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl <= `DSEF_RST_CTRL;
      max_current <= `DSEF_RST_MAX_CURRENT;
      stop_current <= `DSEF_RST_STOP_CURRENT;
      err_mask <= `DSEF_RST_ERR_MASK;
      warn_mask <= `DSEF_RST_WARN_MASK;
      jitter_time <= `DSEF_RST_JITTER_TIME;
      ack_time <= `DSEF_RST_ACK_TIME;
      irq_enable <= `DSEF_RST_IRQ_ENABLE;
    end else if (wr_en) begin
      if (sel_ctrl) ctrl <= pwdata[5:0];
      if (sel_max) max_current <= pwdata[15:0];
      if (sel_stop) stop_current <= pwdata[15:0];
      if (sel_emask) err_mask <= pwdata[2:0];
      if (sel_wmask) warn_mask <= pwdata[0:0];
      if (sel_jit) jitter_time <= pwdata[15:0];
      if (sel_ack) ack_time <= pwdata[15:0];
      if (sel_ien) irq_enable <= pwdata[`DSEF_EV_W-1:0];
    end
  end

  // --------------------------------------------------------------------
  // sticky events and interrupt
  // --------------------------------------------------------------------
  // an event in the clear cycle survives: set wins over clear
  wire [`DSEF_EV_W-1:0] irq_clr = (wr_en & sel_iclr) ? pwdata[`DSEF_EV_W-1:0] : '0;
  wire [`DSEF_EV_W-1:0] next_irq_status = (irq_status & ~irq_clr) | events;
  wire next_error = |(next_irq_status[2:0] & err_mask); // R9 R10 R11

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_status <= '0;
      error_state <= 1'b0;
      warning <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      error_state <= next_error;
      warning <= sensor_misconnect & warn_mask[0]; // R12
      irq <= |(next_irq_status & irq_enable);
    end
  end

  // --------------------------------------------------------------------
  // microsecond tick
  // --------------------------------------------------------------------
  localparam int TICK_CYC = `DSEF_TICK_CYCLES;
  logic [4:0] tick_div;
  wire tick = tick_div == 5'(TICK_CYC - 1);

  always_ff @(posedge mclk) begin
    if (!rst_n) tick_div <= 5'h00;
    else tick_div <= tick ? 5'h00 : tick_div + 5'h01;
  end

  // --------------------------------------------------------------------
  // select input debounce
  // --------------------------------------------------------------------
  logic [3:0] sel_s;
  logic estop_s;
  logic [3:0] cand;
  logic [16:0] stab_cnt;

  dsef_sync2 #(.W(5)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({estop_in, sel_in}), // R1
    .sync_out({estop_s, sel_s})
  );

  wire sel_moved = sel_s != cand;
  // strictly greater: the tick runs free, so the first counted tick may be a partial one
  wire stable = stab_cnt > {1'b0, jitter_time};
  wire adopt = ~sel_moved & stable & (cand != drive_state); // R2

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cand <= 4'h0;
      stab_cnt <= 17'h0_0000;
      drive_state <= 4'h0;
      state_strobe <= 1'b0;
    end else begin
      cand <= sel_s;
      if (sel_moved) stab_cnt <= 17'h0_0000; // R3
      else if (tick && !stable) stab_cnt <= stab_cnt + 17'h0_0001;
      if (adopt) drive_state <= cand; // R2
      state_strobe <= adopt;
    end
  end

  // --------------------------------------------------------------------
  // in-position acknowledge
  // --------------------------------------------------------------------
  logic [16:0] ack_cnt;
  // one extra tick so the low time is never shorter than programmed
  wire ack_done = ack_cnt > {1'b0, ack_time};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_cnt <= 17'h0_0000;
      in_position <= 1'b0;
    end else if (state_strobe) begin
      ack_cnt <= 17'h0_0000; // R4
      in_position <= 1'b0;
    end else begin
      if (tick && !ack_done) ack_cnt <= ack_cnt + 17'h0_0001;
      in_position <= ack_done & at_target; // R5
    end
  end

  // --------------------------------------------------------------------
  // current ceiling and emergency stop
  // --------------------------------------------------------------------
  wire range_hi = ctrl[`DSEF_CTRL_RANGE_BIT];
  wire dsef_ma_t range_ceil = range_hi ? `DSEF_CEIL_HI_MA : `DSEF_CEIL_LO_MA; // R13
  wire dsef_ma_t ceiling = (max_current < range_ceil) ? max_current : range_ceil; // R14
  wire dsef_ma_t run_cmd = (setpoint_ma > ceiling) ? ceiling : setpoint_ma;
  wire dsef_ma_t stop_cmd = (stop_current > ceiling) ? ceiling : stop_current;
  // an unused mode code falls back to removing current, the safe choice
  wire [1:0] mode_code = ctrl[`DSEF_CTRL_ESTOP_LSB +: 2];
  wire mode_freeze = mode_code == DSEF_ESTOP_FREEZE;
  wire mode_set = mode_code == DSEF_ESTOP_SET;
  dsef_ma_t frozen;
  dsef_run_e next_run;
  dsef_ma_t next_cmd;

  always_comb begin
    next_run = run_state;
    unique case (run_state)
      DSEF_RUN: if (estop_s) next_run = DSEF_STOPPED;
      DSEF_STOPPED: if (!estop_s) next_run = DSEF_RUN;
    endcase
  end

  always_comb begin
    if (run_state == DSEF_RUN) next_cmd = run_cmd;
    else if (mode_freeze) next_cmd = frozen; // R7
    else if (mode_set) next_cmd = stop_cmd; // R8
    else next_cmd = 16'h0000; // R6
  end

  assign events = {adopt, run_state == DSEF_RUN && estop_s,
                   sensor_misconnect & warn_mask[0], sensor_absent, curve_fault,
                   motor_type_fault}; // R10 R11

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_state <= DSEF_RUN;
      frozen <= 16'h0000;
      current_cmd_ma <= 16'h0000;
    end else begin
      run_state <= next_run;
      if (run_state == DSEF_RUN && estop_s) frozen <= current_cmd_ma; // R7
      current_cmd_ma <= next_cmd;
    end
  end

  // --------------------------------------------------------------------
  // sensor configuration
  // --------------------------------------------------------------------
  wire [1:0] pitch_code = ctrl[`DSEF_CTRL_PITCH_LSB +: 2];
  wire [15:0] next_pitch = (pitch_code == DSEF_PITCH_5MM) ? `DSEF_PITCH_5MM_UM :
                           (pitch_code == DSEF_PITCH_2MM) ? `DSEF_PITCH_2MM_UM :
                           `DSEF_PITCH_1MM_UM; // R15
  wire dir_neg = ctrl[`DSEF_CTRL_DIR_NEG_BIT];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pitch_um <= `DSEF_PITCH_1MM_UM;
      travel_outward <= 1'b0;
    end else begin
      pitch_um <= next_pitch;
      travel_outward <= sin_leads_cos ^ dir_neg; // R16
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  state_change_a: assert property ($changed(drive_state) |-> state_strobe) // R2
    else $error("drive state changed without adoption strobe");
  timer_restart_a: assert property (sel_moved |=> stab_cnt == 17'h0_0000) // R3
    else $error("stability timer not restarted on select change");
  ack_low_a: assert property (state_strobe |=> !in_position [*2]) // R4
    else $error("in position not held low after command");
  inpos_rise_a: assert property ($rose(in_position) |-> $past(ack_done) && $past(at_target)) // R5
    else $error("in position rose before ack time or target");
  estop_off_a: assert property (run_state == DSEF_STOPPED && !mode_freeze && !mode_set
      |=> current_cmd_ma == 16'h0000) // R6
    else $error("current not removed in off stop mode");
  estop_freeze_a: assert property (run_state == DSEF_RUN && estop_s ##1 mode_freeze
      |=> current_cmd_ma == $past(frozen)) // R7
    else $error("frozen current not held");
  estop_set_a: assert property (run_state == DSEF_STOPPED && mode_set
      |=> current_cmd_ma == $past(stop_cmd)) // R8
    else $error("stop current not driven");
  motor_err_a: assert property (motor_type_fault && err_mask[0] |=> error_state) // R9
    else $error("motor type fault did not raise error state");
  curve_err_a: assert property (curve_fault && err_mask[1] |=> error_state && irq_status[1]) // R10
    else $error("profile lookup fault not flagged");
  sensor_err_a: assert property (sensor_absent && err_mask[2] |=> error_state) // R11
    else $error("sensor absent fault did not raise error state");
  sensor_warn_a: assert property (sensor_misconnect && warn_mask[0] |=> warning) // R12
    else $error("sensor mount warning missing");
  ceiling_a: assert property (run_state == DSEF_RUN |=> current_cmd_ma <= $past(ceiling)
      && current_cmd_ma <= ($past(range_hi) ? `DSEF_CEIL_HI_MA : `DSEF_CEIL_LO_MA)) // R13 R14
    else $error("current above ceiling");
  pitch_set_a: assert property (pitch_code == DSEF_PITCH_2MM |=> pitch_um == `DSEF_PITCH_2MM_UM) // R15
    else $error("pitch scale wrong");
  dir_map_a: assert property (##1 travel_outward == ($past(sin_leads_cos) ^ $past(dir_neg))) // R16
    else $error("travel direction mapping wrong");
endmodule // dsef_drive_supervisor

// File: verilog/dsef_sync2.sv
`timescale 1ns/1ps
module dsef_sync2 #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // dsef_sync2
